// ---- logic/ppb_ctrl.sv ----
// peripheral port bus controller: cycle timing, bus strobes, datapath
// Behaviour
// - Each instruction and its bus cycle lasts 200 ns, eight clocks.
// - All timing comes from clk, a 25 ns clock at eight times the instruction rate.
// - Address and data share one 8-bit three-state bus.
// - Five control outputs tell bus direction and address versus data.
// - A port is selected by its address on the bus with the select strobe.
// - The write strobe is high while data is driven, low on reads.
// - Bank selects change with the other strobes, from the command fields.
// - A byte moves from a port on the left bank to the right bank in one cycle.
// - A master clock output follows the instruction cycle.
// - Sixteen 8-bit registers, three kept for addresses and flags.
// - Bus or register byte is rotated and masked, then combined with acc.
// - Select is high only with an address out, write only with data out.
// - Bank select outputs are active low.
`timescale 1ns/1ps
module ppb_ctrl (
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // command side
    input wire logic cmd_valid,
    input wire ppb_pkg::ppb_cmd_t cmd,
    output logic cmd_taken,
    output logic done,
    output logic [7:0] result,
    output logic [7:0] register_zero_accumulator,
    // peripheral bus
    input wire logic [7:0] bus_in,
    output logic [7:0] bus_out,
    output logic bus_oe_n,
    output ppb_pkg::ppb_bus_ctl_t ctl
);
    import ppb_pkg::*;

    logic [PHASE_W-1:0] phase_q, phase_d;
    ppb_cmd_t cur_q, cur_d;
    logic cur_valid_q, cur_valid_d;
    logic [7:0] regs_q [NUM_REGS];
    logic [7:0] bus_s1_q, bus_s2_q;
    logic [7:0] xfer_byte_q;
    ppb_bus_ctl_t ctl_d;
    logic drive_d;
    logic [7:0] drive_val, rd_val;
    logic [8:0] rd_sum;

    function automatic logic in_win(input logic [PHASE_W-1:0] ph,
                                    input logic [PHASE_W-1:0] first,
                                    input logic [PHASE_W-1:0] last);
        in_win = (ph >= first) && (ph <= last);
    endfunction

    function automatic logic [7:0] rotmask(input logic [7:0] v,
                                           input logic [2:0] rot,
                                           input logic [2:0] len);
        logic [15:0] t;
        logic [7:0] m;
        t = {v, v} >> rot;
        m = (len == 3'h0) ? BYTE_ONES : (BYTE_ONES >> (4'h8 - {1'b0, len}));
        rotmask = t[7:0] & m;
    endfunction

    function automatic logic [7:0] alu(input ppb_alu_t op,
                                       input logic [7:0] a,
                                       input logic [7:0] b);
        case (op)
            PPB_ALU_MOVE: alu = a;
            PPB_ALU_ADD: alu = 8'(a + b);
            PPB_ALU_AND: alu = a & b;
            PPB_ALU_XOR: alu = a ^ b;
            default: alu = a;
        endcase
    endfunction

    // eight-clock instruction cycle, new command taken at the wrap
    always_comb begin
        phase_d = (phase_q == PH_LAST) ? '0 : 3'(phase_q + 3'h1);
        cur_d = cur_q;
        cur_valid_d = cur_valid_q;
        if (phase_q == PH_LAST) begin
            cur_d = cmd;
            cur_valid_d = cmd_valid;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            phase_q <= '0;
            cur_q <= '0;
            cur_valid_q <= 1'b0;
            cmd_taken <= 1'b0;
            done <= 1'b0;
        end else begin
            phase_q <= phase_d;
            cur_q <= cur_d;
            cur_valid_q <= cur_valid_d;
            cmd_taken <= (phase_q == PH_LAST) && cmd_valid;
            done <= (phase_q == PH_LAST) && cur_valid_q;
        end
    end

    // bus pins cross in from outside, two flops before use
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            bus_s1_q <= BYTE_RST;
            bus_s2_q <= BYTE_RST;
        end else begin
            bus_s1_q <= bus_in;
            bus_s2_q <= bus_s1_q;
        end
    end

    // drive value; xfer sends the byte caught in the first half
    always_comb begin
        if (cur_d.op == PPB_OP_XFER)
            drive_val = alu(cur_d.alu,
                            rotmask(xfer_byte_q, cur_d.rot, cur_d.len),
                            regs_q[ACC_IDX]);
        else
            drive_val = alu(cur_d.alu,
                            rotmask(regs_q[cur_d.src], cur_d.rot, cur_d.len),
                            regs_q[ACC_IDX]);
        rd_val = alu(cur_q.alu, rotmask(bus_s2_q, cur_q.rot, cur_q.len),
                     regs_q[ACC_IDX]);
        rd_sum = {1'b0, rotmask(bus_s2_q, cur_q.rot, cur_q.len)}
               + {1'b0, regs_q[ACC_IDX]};
    end

    // strobes computed from the next phase so they line up with phase_q
    always_comb begin
        ctl_d = BUS_CTL_RST;
        ctl_d.master_clock = (phase_d < PH_HALF);
        if (cur_valid_d) begin
            ctl_d.port_select_strobe = (cur_d.op == PPB_OP_SELECT)
                && in_win(phase_d, PH_DRV_FIRST, PH_DRV_LAST);
            ctl_d.write_direction_strobe =
                ((cur_d.op == PPB_OP_WRITE)
                 && in_win(phase_d, PH_DRV_FIRST, PH_DRV_LAST))
                || ((cur_d.op == PPB_OP_XFER)
                 && in_win(phase_d, PH_XFER_DRV_FIRST, PH_DRV_LAST));
            if (cur_d.op == PPB_OP_XFER) begin
                // source bank in first half, destination bank in second
                ctl_d.left_bank_select_n =
                    !(cur_d.left_en && (phase_d < PH_HALF));
                ctl_d.right_bank_select_n =
                    !(cur_d.right_en && (phase_d >= PH_HALF));
            end else begin
                ctl_d.left_bank_select_n = !cur_d.left_en;
                ctl_d.right_bank_select_n = !cur_d.right_en;
            end
        end
        drive_d = ctl_d.port_select_strobe || ctl_d.write_direction_strobe;
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            ctl <= BUS_CTL_RST;
            bus_oe_n <= 1'b1;
            bus_out <= BYTE_RST;
        end else begin
            ctl <= ctl_d;
            bus_oe_n <= !drive_d;
            bus_out <= drive_d ? drive_val : BYTE_RST;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n)
            xfer_byte_q <= BYTE_RST;
        else if (cur_valid_q && cur_q.op == PPB_OP_XFER
                 && phase_q == PH_XFER_SAMPLE)
            xfer_byte_q <= bus_s2_q;
    end

    // working registers: read results, select address copies, carry flag
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            for (int i = 0; i < NUM_REGS; i++)
                regs_q[i] <= BYTE_RST;
        end else if (cur_valid_q) begin
            if (cur_q.op == PPB_OP_READ && phase_q == PH_RD_SAMPLE) begin
                regs_q[cur_q.dst] <= rd_val;
                if (cur_q.alu == PPB_ALU_ADD && cur_q.dst != FLAG_IDX)
                    regs_q[FLAG_IDX] <= {7'h00, rd_sum[8]};
            end
            if (cur_q.op == PPB_OP_SELECT && phase_q == PH_DRV_FIRST) begin
                if (cur_q.left_en)
                    regs_q[LADDR_IDX] <= bus_out;
                if (cur_q.right_en)
                    regs_q[RADDR_IDX] <= bus_out;
            end
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            result <= BYTE_RST;
            register_zero_accumulator <= BYTE_RST;
        end else begin
            register_zero_accumulator <= regs_q[ACC_IDX];
            if (cur_valid_q && cur_q.op == PPB_OP_READ
                && phase_q == PH_RD_SAMPLE)
                result <= rd_val;
            else if (!bus_oe_n && phase_q == PH_DRV_LAST)
                result <= bus_out;
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    sequence s_mclk_high;
        ctl.master_clock [*4];
    endsequence
    sequence s_mclk_low;
        !ctl.master_clock [*4];
    endsequence

    chk_instr_period: assert property (
        phase_q == '0 |-> ##7 (phase_q == PH_LAST) ##1 (phase_q == '0))
        else $error("instruction cycle not eight clocks");
    // first high half after reset is one clock short, phase 0 sat in reset
    chk_mclk_half: assert property (
        ($rose(ctl.master_clock) && $past(rst_n, 2))
        |-> s_mclk_high ##1 s_mclk_low)
        else $error("master clock not half-cycle square wave");
    chk_drive_owner: assert property (
        !bus_oe_n |-> (ctl.port_select_strobe
                       || ctl.write_direction_strobe))
        else $error("bus driven without strobe");
    chk_strobe_excl: assert property (
        !(ctl.port_select_strobe && ctl.write_direction_strobe))
        else $error("select and write together");
    chk_select_hold: assert property (
        $rose(ctl.port_select_strobe) |-> !bus_oe_n
        ##1 (ctl.port_select_strobe && $stable(bus_out)) [*5]
        ##1 !ctl.port_select_strobe)
        else $error("select strobe window wrong");
    chk_read_no_wc: assert property (
        (cur_valid_q && cur_q.op == PPB_OP_READ)
        |-> (!ctl.write_direction_strobe && bus_oe_n))
        else $error("write strobe or drive during read");
    chk_bank_fields: assert property (
        (cur_valid_q && cur_q.op != PPB_OP_XFER)
        |-> (ctl.left_bank_select_n == !cur_q.left_en
             && ctl.right_bank_select_n == !cur_q.right_en))
        else $error("bank select not from command");
    chk_xfer_cycle: assert property (
        (cur_valid_q && cur_q.op == PPB_OP_XFER && phase_q == PH_XFER_SAMPLE)
        |-> ##2 (ctl.write_direction_strobe && !bus_oe_n))
        else $error("transfer not driven in same cycle");
    chk_mclk_phase: assert property (
        ($past(rst_n) && phase_q == '0 |-> ctl.master_clock)
        and (phase_q == PH_HALF |-> !ctl.master_clock))
        else $error("master clock off instruction phase");
    chk_read_store: assert property (
        (cur_valid_q && cur_q.op == PPB_OP_READ && phase_q == PH_RD_SAMPLE)
        |=> (regs_q[cur_q.dst] == $past(rd_val)))
        else $error("read result not stored");
    chk_select_gate: assert property (
        ctl.port_select_strobe |-> (!bus_oe_n
                                    && cur_q.op == PPB_OP_SELECT))
        else $error("select strobe without address");
endmodule

// ---- logic/ppb_pkg.sv ----
// shared constants and types for the peripheral port bus controller
package ppb_pkg;
    localparam int CLK_PERIOD_NS = 25;
    localparam int INSTR_PERIOD_NS = 200;
    // longest time, so the division rounds down
    localparam int INSTR_CYCLES = INSTR_PERIOD_NS / CLK_PERIOD_NS;
    localparam int OSC_CYCLES = INSTR_CYCLES / 2;
    localparam int PHASE_W = 3;
    localparam logic [PHASE_W-1:0] PH_LAST = 3'(INSTR_CYCLES - 1);
    localparam logic [PHASE_W-1:0] PH_HALF = 3'(OSC_CYCLES);
    localparam logic [PHASE_W-1:0] PH_DRV_FIRST = 3'h1;
    localparam logic [PHASE_W-1:0] PH_DRV_LAST = 3'h6;
    localparam logic [PHASE_W-1:0] PH_XFER_DRV_FIRST = 3'h5;
    localparam logic [PHASE_W-1:0] PH_RD_SAMPLE = 3'h6;
    localparam logic [PHASE_W-1:0] PH_XFER_SAMPLE = 3'h3;
    localparam int NUM_REGS = 16;
    localparam logic [3:0] ACC_IDX = 4'h0;
    localparam logic [3:0] LADDR_IDX = 4'h7;
    localparam logic [3:0] FLAG_IDX = 4'h8;
    localparam logic [3:0] RADDR_IDX = 4'hf;
    localparam logic [7:0] BYTE_RST = 8'h00;
    localparam logic [7:0] BYTE_ONES = 8'hff;

    typedef enum logic [1:0] {
        PPB_OP_SELECT, PPB_OP_WRITE, PPB_OP_READ, PPB_OP_XFER
    } ppb_op_t;

    typedef enum logic [1:0] {
        PPB_ALU_MOVE, PPB_ALU_ADD, PPB_ALU_AND, PPB_ALU_XOR
    } ppb_alu_t;

    typedef struct packed {
        ppb_op_t op;
        ppb_alu_t alu;
        logic left_en;
        logic right_en;
        logic [3:0] src;
        logic [3:0] dst;
        logic [2:0] rot;
        logic [2:0] len;
    } ppb_cmd_t;

    typedef struct packed {
        logic port_select_strobe;
        logic write_direction_strobe;
        logic left_bank_select_n;
        logic right_bank_select_n;
        logic master_clock;
    } ppb_bus_ctl_t;

    localparam ppb_bus_ctl_t BUS_CTL_RST = '{1'b0, 1'b0, 1'b1, 1'b1, 1'b0};
endpackage

// ---- sim/ppb_port_model.sv ----
// far-side i/o ports on the left and right banks
`timescale 1ns/1ps
module ppb_port_model (
    // clock
    input wire logic clk,
    // bus side
    input wire ppb_pkg::ppb_bus_ctl_t ctl,
    input wire logic [7:0] bus,
    output logic drv_en,
    output logic [7:0] drv_val
);
    import ppb_pkg::*;
    logic [7:0] lmem [256];
    logic [7:0] rmem [256];
    logic [7:0] lsel_q = 8'h00;
    logic [7:0] rsel_q = 8'h00;
    logic lon;
    logic ron;
    logic quiet;
    initial begin
        for (int a = 0; a < 256; a++) begin
            lmem[a] = 8'(a + 8'h31);
            rmem[a] = 8'(a) ^ 8'hc3;
        end
    end
    assign lon = !ctl.left_bank_select_n;
    assign ron = !ctl.right_bank_select_n;
    assign quiet = !ctl.port_select_strobe && !ctl.write_direction_strobe;
    // answers whenever enabled and idle, so a late read still sees data
    assign drv_en = quiet && (lon || ron);
    assign drv_val = lon ? lmem[lsel_q] : rmem[rsel_q];
    always @(posedge clk) begin
        if (ctl.port_select_strobe && lon) lsel_q <= bus;
        if (ctl.port_select_strobe && ron) rsel_q <= bus;
        if (ctl.write_direction_strobe && lon) lmem[lsel_q] <= bus;
        if (ctl.write_direction_strobe && ron) rmem[rsel_q] <= bus;
    end
endmodule

// ---- sim/tb_peripheral_port_bus_control.sv ----
// self-checking bench for the peripheral port bus controller
`timescale 1ns/1ps
module tb_peripheral_port_bus_control;
    import ppb_pkg::*;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic cmd_valid = 1'b0;
    ppb_cmd_t cmd = '0;
    logic cmd_taken, done, bus_oe_n, drv_en;
    logic [7:0] result, acc, bus_out, drv_val, bus;
    logic [7:0] last_q = 8'h00;
    ppb_bus_ctl_t ctl;
    int n_fail = 0;
    int checks_done = 0;
    int cycles = 0;
    int mclk_gap = 0;
    int mclk_rises = 0;
    ppb_alu_t alu_sel = PPB_ALU_MOVE;
    logic mclk_was = 1'b0;

    always #12.5 clk = ~clk;
    // undriven bus keeps changing, so a stale value never reads as good
    assign bus = !bus_oe_n ? bus_out : drv_en ? drv_val : ~last_q;
    always @(posedge clk) last_q <= bus;

    ppb_ctrl i_dut (.clk(clk), .rst_n(rst_n), .cmd_valid(cmd_valid),
        .cmd(cmd), .cmd_taken(cmd_taken), .done(done), .result(result),
        .register_zero_accumulator(acc), .bus_in(bus), .bus_out(bus_out),
        .bus_oe_n(bus_oe_n), .ctl(ctl));
    ppb_port_model i_port (.clk(clk), .ctl(ctl), .bus(bus),
        .drv_en(drv_en), .drv_val(drv_val));

    task automatic finish_test();
        $display("fails %0d checks %0d", n_fail, checks_done);
        if (n_fail == 0 && checks_done > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    task automatic chk(string what, logic [7:0] exp, logic [7:0] got);
        checks_done++;
        if (got !== exp) begin
            $display("BAD %s exp %h got %h", what, exp, got);
            n_fail++;
        end
    endtask

    task automatic run(ppb_op_t op, logic l, logic r, logic [3:0] s,
            logic [3:0] d, logic [2:0] rot, logic [2:0] len);
        int n;
        n = 0;
        @(posedge clk);
        cmd_valid <= 1'b1;
        cmd <= '{op, alu_sel, l, r, s, d, rot, len};
        do begin
            @(negedge clk);
            n++;
        end while (cmd_taken !== 1'b1 && n < 20);
        @(posedge clk);
        cmd_valid <= 1'b0;
        n = 0;
        do begin
            @(negedge clk);
            n++;
        end while (done !== 1'b1 && n < 20);
        chk("cycle length", 8'h08, 8'(n));
    endtask

    task automatic t_reset();
        repeat (12) @(posedge clk);
        chk("reset ctl", {3'h0, BUS_CTL_RST}, {3'h0, ctl});
        chk("reset drive", 8'h01, {7'h00, bus_oe_n});
        rst_n <= 1'b1;
    endtask

    task automatic t_read_left();
        run(PPB_OP_SELECT, 1'b1, 1'b0, 4'h0, 4'h0, 3'h0, 3'h0);
        run(PPB_OP_READ, 1'b1, 1'b0, 4'h0, 4'h1, 3'h0, 3'h0);
        chk("read left", 8'h31, result);
        chk("acc kept", 8'h00, acc);
    endtask

    task automatic t_rotate_read();
        run(PPB_OP_SELECT, 1'b1, 1'b0, 4'h1, 4'h0, 3'h0, 3'h0);
        run(PPB_OP_READ, 1'b1, 1'b0, 4'h0, 4'h2, 3'h4, 3'h4);
        chk("rotate mask", 8'h06, result);
    endtask

    task automatic t_shared_addr();
        run(PPB_OP_SELECT, 1'b0, 1'b1, 4'h1, 4'h0, 3'h0, 3'h0);
        run(PPB_OP_READ, 1'b0, 1'b1, 4'h0, 4'h3, 3'h0, 3'h0);
        chk("read right", 8'hf2, result);
    endtask

    task automatic t_write();
        run(PPB_OP_WRITE, 1'b0, 1'b1, 4'h2, 4'h0, 3'h0, 3'h0);
        chk("write right", 8'h06, i_port.rmem[8'h31]);
        chk("left intact", 8'h62, i_port.lmem[8'h31]);
    endtask

    task automatic t_xfer();
        run(PPB_OP_XFER, 1'b1, 1'b1, 4'h0, 4'h0, 3'h0, 3'h0);
        chk("xfer dest", 8'h62, i_port.rmem[8'h31]);
        chk("xfer result", 8'h62, result);
    endtask

    // every alu mode against the accumulator, ports hold 8'h62 here
    task automatic t_alu();
        run(PPB_OP_READ, 1'b1, 1'b0, 4'h0, 4'h0, 3'h0, 3'h0);
        chk("acc load", 8'h62, acc);
        alu_sel = PPB_ALU_ADD;
        run(PPB_OP_READ, 1'b0, 1'b1, 4'h0, 4'h4, 3'h0, 3'h0);
        chk("add acc", 8'hc4, result);
        alu_sel = PPB_ALU_AND;
        run(PPB_OP_READ, 1'b1, 1'b0, 4'h0, 4'h5, 3'h4, 3'h0);
        chk("and acc", 8'h22, result);
        alu_sel = PPB_ALU_XOR;
        run(PPB_OP_READ, 1'b1, 1'b0, 4'h0, 4'h6, 3'h4, 3'h0);
        chk("xor acc", 8'h44, result);
        alu_sel = PPB_ALU_MOVE;
        chk("clock running", 8'h01, {7'h00, mclk_rises > 20});
    endtask

    // strobe and clock relations watched all through the run
    always @(negedge clk) begin
        if (rst_n) begin
            if (!bus_oe_n && !ctl.port_select_strobe &&
                    !ctl.write_direction_strobe) begin
                $display("BAD drive without strobe exp 1 got 0");
                n_fail++;
            end
            if (drv_en && !bus_oe_n) begin
                $display("BAD bus clash exp 0 got 1");
                n_fail++;
            end
            if (ctl.master_clock && !mclk_was) begin
                // period after the first rise is short, reset ate phase 0
                if (mclk_rises > 1 && mclk_gap != 8) begin
                    $display("BAD clock period exp 8 got %0d", mclk_gap);
                    n_fail++;
                end
                mclk_rises++;
                mclk_gap = 1;
            end else begin
                mclk_gap++;
            end
            mclk_was = ctl.master_clock;
        end
    end

    always @(posedge clk) begin
        cycles++;
        if (cycles == 1000) begin
            n_fail++;
            finish_test();
        end
    end

    initial begin
        t_reset();
        t_read_left();
        t_rotate_read();
        t_shared_addr();
        t_write();
        t_xfer();
        t_alu();
        finish_test();
    end
endmodule
